//--- logic/muldiv_logic_pkg.sv
// Purpose: shared constants and carriers for the multiply/divide/logic decoder
// Assumes: opcode byte first, operand-select byte second, as fetched
// Notes:   cycle figures are processor clocks; ranges carry low and high bounds
package muldiv_logic_pkg;

  // fetched instruction bytes, oldest first
  typedef struct packed {
    logic [7:0] op;     // opcode byte
    logic [7:0] modrm;  // operand-select byte or second opcode byte
  } instr_bytes_t;

  // clock count range, low and high bound
  typedef struct packed {
    logic [6:0] lo;
    logic [6:0] hi;
  } cyc_range_t;

  // decoded operation kinds
  typedef enum logic [3:0] {
    K_NONE, K_SIGNED_MULTIPLY, K_IMM_SIGNED_MULTIPLY, K_UNSIGNED_DIVIDE,
    K_SIGNED_DIVIDE, K_ASCII_MULT_ADJUST, K_ASCII_DIV_ADJUST,
    K_BYTE_TO_WORD_SIGN_EXTEND, K_WORD_TO_DWORD_SIGN_EXTEND,
    K_AND, K_OR, K_TEST
  } op_kind_t;

  // decoder result, one per accepted instruction
  typedef struct packed {
    logic       valid;      // result present this cycle
    logic       known;      // opcode belongs to this group
    op_kind_t   kind;       // operation
    logic       word;       // 1 word, 0 byte
    logic       to_reg;     // result written to the reg field register
    logic       is_mem;     // operand in memory
    logic       has_modrm;  // operand-select byte used
    logic       flags_only; // flags updated, no result written
    logic [1:0] imm_bytes;  // immediate data bytes following
    logic [2:0] length;     // bytes, displacement excluded
    cyc_range_t cyc;        // execution clocks
  } decode_t;

  // opcode patterns (upper bits, width bit stripped)
  localparam logic [6:0] OP_GROUP3    = 7'h7B; // 1111011w
  localparam logic [6:0] OP_IMM_GROUP = 7'h40; // 1000000w
  localparam logic [5:0] OP_AND_RM    = 6'h08; // 001000dw
  localparam logic [5:0] OP_OR_RM     = 6'h02; // 000010dw
  localparam logic [6:0] OP_TEST_RM   = 7'h42; // 1000010w
  localparam logic [6:0] OP_TEST_ACC  = 7'h54; // 1010100w
  localparam logic [6:0] OP_AND_ACC   = 7'h12; // 0010010w
  localparam logic [6:0] OP_OR_ACC    = 7'h06; // 0000110w
  localparam logic [5:0] OP_MULT_IMM  = 6'h1A; // 011010s1
  localparam logic [7:0] OP_MULT_ADJ  = 8'hD4;
  localparam logic [7:0] OP_DIV_ADJ   = 8'hD5;
  localparam logic [7:0] ADJ_BASE     = 8'h0A;
  localparam logic [7:0] OP_BYTE_EXT  = 8'h98;
  localparam logic [7:0] OP_WORD_EXT  = 8'h99;

  // field positions and values
  localparam int         POS_W     = 0;
  localparam int         POS_D     = 1;
  localparam int         POS_S     = 1;
  localparam logic [1:0] MOD_REG   = 2'h3;
  localparam logic [2:0] SEL_TEST  = 3'h0;
  localparam logic [2:0] SEL_OR    = 3'h1;
  localparam logic [2:0] SEL_AND   = 3'h4;
  localparam logic [2:0] SEL_SMULT = 3'h5;
  localparam logic [2:0] SEL_DIV   = 3'h6;
  localparam logic [2:0] SEL_SDIV  = 3'h7;

  // clock counts
  localparam cyc_range_t CYC_SMUL_RB  = '{lo: 7'h19, hi: 7'h1C};
  localparam cyc_range_t CYC_SMUL_RW  = '{lo: 7'h22, hi: 7'h25};
  localparam cyc_range_t CYC_SMUL_MB  = '{lo: 7'h1F, hi: 7'h22};
  localparam cyc_range_t CYC_SMUL_MW  = '{lo: 7'h28, hi: 7'h2B};
  localparam cyc_range_t CYC_SMULI_R  = '{lo: 7'h16, hi: 7'h19};
  localparam cyc_range_t CYC_SMULI_M  = '{lo: 7'h1D, hi: 7'h20};
  localparam cyc_range_t CYC_SDIV_RB  = '{lo: 7'h2C, hi: 7'h34};
  localparam cyc_range_t CYC_SDIV_RW  = '{lo: 7'h35, hi: 7'h3D};
  localparam cyc_range_t CYC_SDIV_MB  = '{lo: 7'h32, hi: 7'h3A};
  localparam cyc_range_t CYC_SDIV_MW  = '{lo: 7'h3B, hi: 7'h43};
  localparam logic [6:0] CYC_DIV_RB   = 7'h1D;
  localparam logic [6:0] CYC_DIV_RW   = 7'h26;
  localparam logic [6:0] CYC_DIV_MB   = 7'h23;
  localparam logic [6:0] CYC_DIV_MW   = 7'h2C;
  localparam logic [6:0] CYC_MULT_ADJ = 7'h13;
  localparam logic [6:0] CYC_DIV_ADJ  = 7'h0F;
  localparam logic [6:0] CYC_BYTE_EXT = 7'h02;
  localparam logic [6:0] CYC_WORD_EXT = 7'h04;
  localparam logic [6:0] CYC_LOG_REG  = 7'h03;
  localparam logic [6:0] CYC_LOG_MEM  = 7'h0A;
  localparam logic [6:0] CYC_IMM_REG  = 7'h04;
  localparam logic [6:0] CYC_IMM_MEM  = 7'h10;
  localparam logic [6:0] CYC_TSTI_MEM = 7'h0A;
  localparam logic [6:0] CYC_ACC_BYTE = 7'h03;
  localparam logic [6:0] CYC_ACC_WORD = 7'h04;

  // lengths and reset value
  localparam logic [2:0] LEN_OP       = 3'h1;
  localparam logic [2:0] LEN_OP_MODRM = 3'h2;
  localparam decode_t    DECODE_RESET = '0;

endpackage

//--- logic/muldiv_logic_op_decoder.sv
// Purpose: decode multiply, divide, adjust, sign-extend and AND/OR/TEST
//          instructions, giving operand use, length and execution clocks
// Assumes: in_bytes comes from logic on clk; no synchroniser needed
// Notes:   result appears one clock after in_valid; length excludes displacement
//
// What this block does
// RULE1 - signed multiply: group opcode, select 101, clocks
// RULE2 - immediate signed multiply: data, sign bit, clocks
// RULE3 - unsigned divide: group opcode, select 110, clocks
// RULE4 - signed divide: group opcode, select 111, clocks
// RULE5 - multiply adjust: D4 then 0A, 19 clocks
// RULE6 - divide adjust: D5 then 0A, 15 clocks
// RULE7 - byte to word sign extend, 2 clocks
// RULE8 - word to doubleword sign extend, 4 clocks
// RULE9 - AND/OR register and immediate forms, clocks
// RULE10 - flag-only AND register form, 3/10 clocks
// RULE11 - flag-only AND immediate, select 000, 4/10
// RULE12 - flag-only AND accumulator immediate, 3/4 clocks
// RULE13 - width bit word, direction bit targets register
// RULE14 - output clock count matching operand kind
`timescale 1ns/1ps

module muldiv_logic_op_decoder
(
  input  wire logic                          clk,      // core clock, 50 MHz
  input  wire logic                          rst,      // async, active high
  input  wire logic                          in_valid, // bytes present this cycle
  input  wire muldiv_logic_pkg::instr_bytes_t in_bytes, // opcode and next byte
  output muldiv_logic_pkg::decode_t          dec       // registered result
);
  import muldiv_logic_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // memory operand whenever mod is not the register form
  function automatic logic mod_is_mem(input logic [7:0] modrm);
    mod_is_mem = (modrm[7:6] != MOD_REG);
  endfunction

  // fixed clock count as a degenerate range
  function automatic cyc_range_t fixed(input logic [6:0] c);
    fixed = '{lo: c, hi: c};
  endfunction

  // pick among register/memory and byte/word
  function automatic cyc_range_t pick4(input logic mem, input logic wd,
                                       input cyc_range_t rb, input cyc_range_t rw,
                                       input cyc_range_t mb, input cyc_range_t mw);
    if (mem)
    begin
      pick4 = wd ? mw : mb;
    end
    else
    begin
      pick4 = wd ? rw : rb;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // decode

  decode_t    dec_reg;   // result register
  decode_t    dec_next;  // next result
  logic [7:0] op;        // opcode byte
  logic [7:0] mb;        // operand-select byte
  logic [2:0] sel;       // middle field of operand-select byte
  logic       wbit;      // width bit
  logic       mem;       // operand in memory

  assign op   = in_bytes.op;
  assign mb   = in_bytes.modrm;
  assign sel  = mb[5:3];
  assign wbit = op[POS_W];   // RULE13
  assign mem  = mod_is_mem(mb);

  // combinational decode of the presented bytes
  always_comb
  begin
    dec_next       = DECODE_RESET;
    dec_next.valid = in_valid;
    dec_next.word  = wbit; // RULE13
    if (op[7:1] == OP_GROUP3)
    begin
      // multiply, divide and flag-only immediate share this opcode
      dec_next.has_modrm = 1'b1;
      dec_next.is_mem    = mem;
      dec_next.length    = LEN_OP_MODRM;
      unique case (sel)
        SEL_SMULT:
        begin
          dec_next.known = 1'b1; // RULE1
          dec_next.kind  = K_SIGNED_MULTIPLY;
          dec_next.cyc   = pick4(mem, wbit, CYC_SMUL_RB, CYC_SMUL_RW,
                                 CYC_SMUL_MB, CYC_SMUL_MW); // RULE1 RULE14
        end
        SEL_DIV:
        begin
          dec_next.known = 1'b1; // RULE3
          dec_next.kind  = K_UNSIGNED_DIVIDE;
          dec_next.cyc   = pick4(mem, wbit, fixed(CYC_DIV_RB), fixed(CYC_DIV_RW),
                                 fixed(CYC_DIV_MB), fixed(CYC_DIV_MW)); // RULE3 RULE14
        end
        SEL_SDIV:
        begin
          dec_next.known = 1'b1; // RULE4
          dec_next.kind  = K_SIGNED_DIVIDE;
          dec_next.cyc   = pick4(mem, wbit, CYC_SDIV_RB, CYC_SDIV_RW,
                                 CYC_SDIV_MB, CYC_SDIV_MW); // RULE4 RULE14
        end
        SEL_TEST:
        begin
          dec_next.known      = 1'b1; // RULE11
          dec_next.kind       = K_TEST;
          dec_next.flags_only = 1'b1;
          dec_next.imm_bytes  = wbit ? 2'h2 : 2'h1; // RULE11
          dec_next.length     = LEN_OP_MODRM + {1'b0, dec_next.imm_bytes};
          dec_next.cyc        = fixed(mem ? CYC_TSTI_MEM : CYC_IMM_REG); // RULE11 RULE14
        end
        default:
        begin
          // other selects of this opcode belong to neighbouring groups
          dec_next.has_modrm = 1'b0;
          dec_next.is_mem    = 1'b0;
          dec_next.length    = '0;
        end
      endcase
    end
    else if (op[7:2] == OP_MULT_IMM && op[POS_W])
    begin
      // sign bit set means one data byte sign-extended, else two
      dec_next.known     = 1'b1; // RULE2
      dec_next.kind      = K_IMM_SIGNED_MULTIPLY;
      dec_next.word      = 1'b1;
      dec_next.to_reg    = 1'b1;
      dec_next.has_modrm = 1'b1;
      dec_next.is_mem    = mem;
      dec_next.imm_bytes = op[POS_S] ? 2'h1 : 2'h2; // RULE2
      dec_next.length    = LEN_OP_MODRM + {1'b0, dec_next.imm_bytes};
      dec_next.cyc       = mem ? CYC_SMULI_M : CYC_SMULI_R; // RULE2 RULE14
    end
    else if ((op == OP_MULT_ADJ || op == OP_DIV_ADJ) && mb == ADJ_BASE)
    begin
      // second byte must be the base; any other second byte is not ours
      dec_next.known  = 1'b1; // RULE5 RULE6
      dec_next.kind   = (op == OP_MULT_ADJ) ? K_ASCII_MULT_ADJUST : K_ASCII_DIV_ADJUST;
      dec_next.word   = 1'b0;
      dec_next.length = LEN_OP_MODRM;
      dec_next.cyc    = fixed((op == OP_MULT_ADJ) ? CYC_MULT_ADJ : CYC_DIV_ADJ); // RULE5 RULE6
    end
    else if (op == OP_BYTE_EXT || op == OP_WORD_EXT)
    begin
      dec_next.known  = 1'b1; // RULE7 RULE8
      dec_next.kind   = (op == OP_BYTE_EXT) ? K_BYTE_TO_WORD_SIGN_EXTEND
                                            : K_WORD_TO_DWORD_SIGN_EXTEND;
      dec_next.word   = (op == OP_WORD_EXT);
      dec_next.length = LEN_OP;
      dec_next.cyc    = fixed((op == OP_BYTE_EXT) ? CYC_BYTE_EXT : CYC_WORD_EXT); // RULE7 RULE8
    end
    else if (op[7:2] == OP_AND_RM || op[7:2] == OP_OR_RM)
    begin
      dec_next.known     = 1'b1; // RULE9
      dec_next.kind      = (op[7:2] == OP_AND_RM) ? K_AND : K_OR;
      dec_next.to_reg    = op[POS_D]; // RULE13
      dec_next.has_modrm = 1'b1;
      dec_next.is_mem    = mem;
      dec_next.length    = LEN_OP_MODRM;
      dec_next.cyc       = fixed(mem ? CYC_LOG_MEM : CYC_LOG_REG); // RULE9 RULE14
    end
    else if (op[7:1] == OP_IMM_GROUP && (sel == SEL_AND || sel == SEL_OR))
    begin
      dec_next.known     = 1'b1; // RULE9
      dec_next.kind      = (sel == SEL_AND) ? K_AND : K_OR;
      dec_next.has_modrm = 1'b1;
      dec_next.is_mem    = mem;
      dec_next.imm_bytes = wbit ? 2'h2 : 2'h1;
      dec_next.length    = LEN_OP_MODRM + {1'b0, dec_next.imm_bytes};
      dec_next.cyc       = fixed(mem ? CYC_IMM_MEM : CYC_IMM_REG); // RULE9 RULE14
    end
    else if (op[7:1] == OP_TEST_RM)
    begin
      dec_next.known      = 1'b1; // RULE10
      dec_next.kind       = K_TEST;
      dec_next.flags_only = 1'b1;
      dec_next.has_modrm  = 1'b1;
      dec_next.is_mem     = mem;
      dec_next.length     = LEN_OP_MODRM;
      dec_next.cyc        = fixed(mem ? CYC_LOG_MEM : CYC_LOG_REG); // RULE10 RULE14
    end
    else if (op[7:1] == OP_TEST_ACC || op[7:1] == OP_AND_ACC || op[7:1] == OP_OR_ACC)
    begin
      // accumulator forms carry no operand-select byte
      dec_next.known      = 1'b1; // RULE12
      dec_next.kind       = (op[7:1] == OP_TEST_ACC) ? K_TEST :
                            (op[7:1] == OP_AND_ACC) ? K_AND : K_OR;
      dec_next.flags_only = (op[7:1] == OP_TEST_ACC);
      dec_next.imm_bytes  = wbit ? 2'h2 : 2'h1; // RULE12
      dec_next.length     = LEN_OP + {1'b0, dec_next.imm_bytes};
      dec_next.cyc        = fixed(wbit ? CYC_ACC_WORD : CYC_ACC_BYTE); // RULE12 RULE14
    end
    if (!in_valid)
    begin
      // hold a clean idle value so sequencing never sees stale counts
      dec_next = DECODE_RESET;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // result register

  // registered so the output comes straight from flip-flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dec_reg <= DECODE_RESET;
    end
    else
    begin
      dec_reg <= dec_next;
    end
  end

  assign dec = dec_reg;

endmodule

//--- verification/muldiv_logic_op_decoder_properties.sv
// Purpose: concurrent checks on the decoder ports
// Assumes: one clock domain, rst async active high
// Notes:   every check but unknown_zero_a looks one cycle past the accepted bytes
`timescale 1ns/1ps

module muldiv_logic_op_decoder_properties
(
  input wire logic                           clk,      // core clock
  input wire logic                           rst,      // async reset
  input wire logic                           in_valid, // bytes offered
  input wire muldiv_logic_pkg::instr_bytes_t in_bytes, // opcode and next byte
  input wire muldiv_logic_pkg::decode_t      dec       // registered result
);
  import muldiv_logic_pkg::*;

  // all checks share one clock and one reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  valid_pulse_a: assert property (in_valid |=> dec.valid)
    else $error("valid missing after request");
  idle_quiet_a: assert property (!in_valid |=> !dec.valid && !dec.known)
    else $error("result without request");
  sdiv_word_a: assert property (in_valid && in_bytes == 16'hF7F8 |=>
    dec.kind == K_SIGNED_DIVIDE && dec.cyc.lo == 7'h35 && dec.cyc.hi == 7'h3D)
    else $error("signed divide word register wrong");
  div_mem_byte_a: assert property (in_valid && in_bytes == 16'hF630 |=>
    dec.kind == K_UNSIGNED_DIVIDE && dec.cyc.lo == 7'h23 && dec.cyc.hi == 7'h23)
    else $error("unsigned divide byte memory wrong");
  mult_adjust_a: assert property (in_valid && in_bytes == 16'hD40A |=>
    dec.kind == K_ASCII_MULT_ADJUST && dec.cyc.lo == 7'h13)
    else $error("multiply adjust wrong");
  sign_ext_a: assert property (in_valid && in_bytes.op[7:1] == 7'h4C |=>
    dec.length == 3'h1 && dec.cyc.lo == ($past(in_bytes.op[0]) ? 7'h04 : 7'h02))
    else $error("sign extend wrong");
  and_rm_a: assert property (in_valid && in_bytes.op[7:2] == 6'h08 |=>
    dec.kind == K_AND && dec.to_reg == $past(in_bytes.op[1])
    && dec.cyc.lo == ($past(in_bytes.modrm[7:6]) == 2'h3 ? 7'h03 : 7'h0A))
    else $error("and register form wrong");
  test_acc_a: assert property (in_valid && in_bytes.op[7:1] == 7'h54 |=>
    dec.flags_only && dec.cyc.lo == ($past(in_bytes.op[0]) ? 7'h04 : 7'h03))
    else $error("test accumulator wrong");
  group_hole_a: assert property (in_valid && in_bytes.op[7:1] == 7'h7B
    && in_bytes.modrm[5:3] inside {[3'h1:3'h4]} |=> !dec.known)
    else $error("unused group select decoded");
  unknown_zero_a: assert property (dec.valid && !dec.known |->
    dec.cyc == '0 && dec.length == 3'h0)
    else $error("unknown opcode carries a count");

  // main scenarios reached
  cover property (in_valid ##1 in_valid ##1 dec.valid);
  cover property (dec.valid && dec.kind == K_IMM_SIGNED_MULTIPLY && dec.is_mem);
  cover property (dec.valid && dec.kind == K_TEST && dec.imm_bytes == 2'h2);
endmodule

bind muldiv_logic_op_decoder muldiv_logic_op_decoder_properties i_props (
  .clk(clk), .rst(rst), .in_valid(in_valid), .in_bytes(in_bytes), .dec(dec));

//--- verification/muldiv_logic_op_decoder_tb.sv
// Purpose: self-checking bench for the decoder
// Assumes: result one clock after the request
// Notes:   table sweep of every opcode and select, then random traffic
`timescale 1ns/1ps

module muldiv_logic_op_decoder_tb;
  import muldiv_logic_pkg::*;
  logic         clk;       // 50 MHz core clock
  logic         rst;       // async reset
  logic         in_valid;  // request
  instr_bytes_t in_bytes;  // bytes offered
  decode_t      dec;       // design result
  logic         pv;        // request of the last cycle
  instr_bytes_t pb;        // bytes of the last cycle
  logic [31:0]  seed;      // random state
  int           errors;    // mismatches
  int           tests_run; // comparisons
  logic [7:0]   ops [27] = '{8'hF6, 8'hF7, 8'h80, 8'h81, 8'h20, 8'h21, 8'h22, 8'h23,
    8'h08, 8'h09, 8'h0A, 8'h0B, 8'h84, 8'h85, 8'hA8, 8'hA9, 8'h24, 8'h25, 8'h0C,
    8'h0D, 8'h69, 8'h6B, 8'hD4, 8'hD5, 8'h98, 8'h99, 8'h6A};

  muldiv_logic_op_decoder i_muldiv_logic_op_decoder (
    .clk(clk), .rst(rst), .in_valid(in_valid), .in_bytes(in_bytes), .dec(dec));

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // one known result; hi is lo plus the spread of the count
  function automatic decode_t mk(op_kind_t k, logic w, logic m, logic t, logic f,
                                 logic [1:0] im, logic [2:0] ln, logic [6:0] lo,
                                 logic [6:0] dh);
    return '{valid: 1'b1, known: 1'b1, kind: k, word: w, to_reg: t, is_mem: m,
             has_modrm: 1'b0, flags_only: f, imm_bytes: im, length: ln,
             cyc: '{lo: lo, hi: lo + dh}};
  endfunction

  // expected result from the opcode tables
  function automatic decode_t ref_dec(instr_bytes_t b);
    logic       w;
    logic       m;
    logic [2:0] s;
    logic [1:0] im;
    logic [6:0] o;
    w = b.op[0];
    m = b.modrm[7:6] != 2'h3;
    s = b.modrm[5:3];
    im = w ? 2'h2 : 2'h1;
    o = b.op[7:1];
    ref_dec = '0;
    ref_dec.valid = 1'b1;
    if (o == 7'h7B && s == 3'h5)
      ref_dec = mk(K_SIGNED_MULTIPLY, w, m, 0, 0, 0, 2, m ? (w ? 40 : 31) : (w ? 34 : 25), 3);
    else if (o == 7'h7B && s == 3'h6)
      ref_dec = mk(K_UNSIGNED_DIVIDE, w, m, 0, 0, 0, 2, m ? (w ? 44 : 35) : (w ? 38 : 29), 0);
    else if (o == 7'h7B && s == 3'h7)
      ref_dec = mk(K_SIGNED_DIVIDE, w, m, 0, 0, 0, 2, m ? (w ? 59 : 50) : (w ? 53 : 44), 8);
    else if (o == 7'h7B && s == 3'h0)
      ref_dec = mk(K_TEST, w, m, 0, 1, im, 3'h2 + im, m ? 10 : 4, 0);
    else if (b.op[7:2] == 6'h1A && w)
      ref_dec = mk(K_IMM_SIGNED_MULTIPLY, 1, m, 1, 0, 2'h2 - b.op[1],
                   3'h4 - b.op[1], m ? 29 : 22, 3);
    else if (b == 16'hD40A)
      ref_dec = mk(K_ASCII_MULT_ADJUST, 0, 0, 0, 0, 0, 2, 19, 0);
    else if (b == 16'hD50A)
      ref_dec = mk(K_ASCII_DIV_ADJUST, 0, 0, 0, 0, 0, 2, 15, 0);
    else if (b.op == 8'h98)
      ref_dec = mk(K_BYTE_TO_WORD_SIGN_EXTEND, 0, 0, 0, 0, 0, 1, 2, 0);
    else if (b.op == 8'h99)
      ref_dec = mk(K_WORD_TO_DWORD_SIGN_EXTEND, 1, 0, 0, 0, 0, 1, 4, 0);
    else if (b.op[7:2] == 6'h08 || b.op[7:2] == 6'h02)
      ref_dec = mk(b.op[5] ? K_AND : K_OR, w, m, b.op[1], 0, 0, 2, m ? 10 : 3, 0);
    else if (o == 7'h40 && (s == 3'h4 || s == 3'h1))
      ref_dec = mk(s[2] ? K_AND : K_OR, w, m, 0, 0, im, 3'h2 + im, m ? 16 : 4, 0);
    else if (o == 7'h42)
      ref_dec = mk(K_TEST, w, m, 0, 1, 0, 2, m ? 10 : 3, 0);
    else if (o == 7'h54 || o == 7'h12 || o == 7'h06)
      ref_dec = mk(o == 7'h54 ? K_TEST : (o == 7'h12 ? K_AND : K_OR), w, 0, 0,
                   o == 7'h54, im, 3'h1 + im, w ? 4 : 3, 0);
    // every known form reads an operand-select byte but adjust, extend and accumulator
    ref_dec.has_modrm = ref_dec.known && !(b.op inside {8'hD4, 8'hD5, 8'h98, 8'h99})
                        && !(o inside {7'h54, 7'h12, 7'h06});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // compare the last request; width of an unknown opcode is left open
  task automatic check;
    decode_t e;
    decode_t a;
    e = pv ? ref_dec(pb) : '0;
    a = dec;
    if (!e.known)
      a.word = 1'b0;
    tests_run++;
    if (a !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask

  // inputs change 2 ns after the edge, one request per cycle
  task automatic step(logic v, logic [15:0] b);
    @(posedge clk);
    #2;
    check();
    in_valid = v;
    in_bytes = b;
    pv = v;
    pb = b;
  endtask

  task automatic wrap_up;
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    in_valid = 1'b0;
    in_bytes = '0;
    pv = 1'b0;
    pb = '0;
    seed = 32'hB11C;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    #2;
    rst = 1'b0;
    // every opcode with every select, register and memory operands
    foreach (ops[i])
      for (int s = 0; s < 8; s++)
      begin
        step(1'b1, {ops[i], 2'h3, 3'(s), 3'h5});
        step(1'b1, {ops[i], 2'h1, 3'(s), 3'h2});
      end
    step(1'b1, 16'hD40A);
    step(1'b1, 16'hD50A);
    step(1'b1, 16'hD50B);
    step(1'b1, 16'hF7F8);
    step(1'b1, 16'hF630);
    for (int n = 0; n < 3000; n++)
    begin
      seed = lfsr(seed);
      if (n == 1500)
      begin
        // reset in mid-run clears the result
        // request left standing so a dead reset would show its decode
        rst = 1'b1;
        pv = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        check();
        in_valid = 1'b0;
        rst = 1'b0;
      end
      step(seed[0] | seed[1], {seed[9] ? ops[int'(seed[20:16]) % 27] : seed[15:8],
                               seed[31:24]});
    end
    step(1'b0, 16'h0000);
    wrap_up();
  end
endmodule
